/* esx_pkg.sv */
// Shared constants and types for the extended stack instruction executor.
// Assumes a 16-bit instruction word and a 12-bit data address space.
package esx_pkg;

   // Opcode patterns.
   localparam logic [7:0] OP_MOVE_HI = 8'hEB;
   localparam logic [7:0] OP_PUSH_HI = 8'hFA;
   localparam logic [7:0] OP_SUB_HI = 8'hE9;
   localparam logic [3:0] OP_WORD2_HI = 4'hF;
   localparam int MOVE_SEL_BIT = 7;
   localparam logic [1:0] SEL_RETURN = 2'h3;

   // Field positions.
   localparam int OFS_MSB = 6;
   localparam int LIT6_MSB = 5;
   localparam int SEL_MSB = 7;
   localparam int SEL_LSB = 6;

   // Address space and indexed literal offset window.
   localparam int ADDR_W = 12;
   localparam int NUM_PTR = 3;
   localparam int STACK_PTR = 2;
   localparam logic [7:0] IDX_LIMIT = 8'h5F;
   localparam logic [3:0] ACC_LOW_BANK = 4'h0;
   localparam logic [3:0] ACC_HIGH_BANK = 4'hF;

   // Pointer reset value, zero byte and one-address decrement step.
   localparam logic [11:0] PTR_RESET = 12'h000;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [11:0] ONE_ADDR = 12'h001;

   typedef enum logic [1:0] {ST_IDLE, ST_MOVE, ST_RET_NOP} esx_fsm_t;

   // Data memory request as driven by the executor.
   typedef struct packed {
      logic rdEn;
      logic [11:0] rdAddr;
      logic wrEn;
      logic [11:0] wrAddr;
      logic [7:0] wrData;
   } esx_mem_req_t;

   typedef struct packed {
      esx_fsm_t fsm;
      logic [2:0][11:0] ptr;
      logic [11:0] destAddr;
      logic destSet;
      logic destNop;
      logic readPend;
      logic dataHeld;
      logic [7:0] srcByte;
      esx_mem_req_t mem;
      logic pcLoad;
      logic [20:0] pcValue;
   } esx_state_t;

endpackage

/* esx_exec.sv */
// Executor for the extended stack instructions and the indexed literal
// offset file address resolver. Assumes the core presents one instruction
// word per accepted cycle and data memory returns read data in the
// same cycle that a read request is presented on memReq.
//
// Contract
// - Indexed move: two words, two cycles; the code takes three, issuing the write on the third edge.
// - Move addresses are stack pointer plus offsets.
// - Indirect source register reads as zero.
// - Indirect destination makes the move a no-op.
// - Literal push is single word, single cycle.
// - Push stores literal, then decrements stack pointer.
// - Pointer subtract decodes select and six-bit literal.
// - Subtract literal from selected pointer, no flags.
// - Select three subtracts stack pointer then returns.
// - Subtract-and-return takes two cycles, second idle.
// - Extension enable also enables indexed offset addressing.
// - Disabled: access bit picks access or selected bank.
// - Enabled, access zero, file up to limit is indexed.
// - Zero stack pointer restores legacy access mapping.
// - Destination bit keeps its normal meaning.
// - Everything extended decodes only when enable set.
// - Destination zero to accumulator, one to register.
`timescale 1ns/100ps

module esx_exec #(
   parameter logic [11:0] IND_BASE0 = 12'hFE0,
   parameter logic [11:0] IND_BASE1 = 12'hFE8,
   parameter logic [11:0] IND_BASE2 = 12'hFF0,
   parameter int IND_SPAN = 5
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic extEnable,
   input wire logic instrValid,
   input wire logic [15:0] instrWord,
   output logic instrAccept,
   output logic extDecoded,
   input wire logic [20:0] tosValue,
   output logic pcLoad,
   output logic [20:0] pcValue,
   output logic nopSlot,
   output esx_pkg::esx_mem_req_t memReq,
   input wire logic [7:0] memRdData,
   input wire logic ptrLoad,
   input wire logic [1:0] ptrLoadSel,
   input wire logic [11:0] ptrLoadData,
   output logic [2:0][11:0] ptrValue,
   input wire logic [7:0] baseFile,
   input wire logic baseAccess,
   input wire logic baseDest,
   input wire logic [3:0] bankSel,
   output logic [11:0] resolvedAddr,
   output logic resolvedIndexed,
   output logic destToAcc
);

   esx_pkg::esx_state_t s_reg;
   esx_pkg::esx_state_t s_next;

   logic [11:0] stackPtr;
   logic [11:0] candAddr;
   logic [2:0] indHitPer;
   logic indHit;
   logic [2:0][11:0] indBase;
   logic decMove;
   logic decPush;
   logic decSub;
   logic [1:0] subSel;
   logic [11:0] subLit;
   logic take;

   assign stackPtr = s_reg.ptr[esx_pkg::STACK_PTR];
   assign subSel = instrWord[esx_pkg::SEL_MSB:esx_pkg::SEL_LSB];
   assign subLit = {6'h00, instrWord[esx_pkg::LIT6_MSB:0]};
   assign indBase = {IND_BASE2, IND_BASE1, IND_BASE0};

   // Both move words carry their offset in the same low seven bits.
   assign candAddr = stackPtr + {5'h00, instrWord[esx_pkg::OFS_MSB:0]};

   genvar gi;
   generate
      for (gi = 0; gi < esx_pkg::NUM_PTR; gi++)
      begin : g_ind
         assign indHitPer[gi] = (candAddr >= indBase[gi]) &&
            (candAddr < indBase[gi] + IND_SPAN[11:0]);
      end
   endgenerate
   assign indHit = |indHitPer;

   // Nothing is taken in the idle slot after a return, and a move holds
   // off further words once its destination word is in.
   assign instrAccept = ce && ((s_reg.fsm == esx_pkg::ST_IDLE) ||
      (s_reg.fsm == esx_pkg::ST_MOVE && !s_reg.destSet));
   assign take = instrValid && instrAccept &&
      (s_reg.fsm == esx_pkg::ST_IDLE);

   assign decMove = take && extEnable &&
      instrWord[15:8] == esx_pkg::OP_MOVE_HI &&
      instrWord[esx_pkg::MOVE_SEL_BIT];
   assign decPush = take && extEnable &&
      instrWord[15:8] == esx_pkg::OP_PUSH_HI;
   assign decSub = take && extEnable &&
      instrWord[15:8] == esx_pkg::OP_SUB_HI;
   assign extDecoded = decMove || decPush || decSub;

   always_comb
   begin
      s_next = s_reg;
      // Pulses drop only on an enabled edge, so a low enable holds them too.
      if (ce)
      begin
         s_next.mem.rdEn = 1'b0;
         s_next.mem.wrEn = 1'b0;
         s_next.pcLoad = 1'b0;
         // Core-side pointer loads; an executing instruction wins below.
         if (ptrLoad && ptrLoadSel < 2'(esx_pkg::NUM_PTR))
         begin
            s_next.ptr[ptrLoadSel] = ptrLoadData;
         end
         case (s_reg.fsm)
            esx_pkg::ST_IDLE:
            begin
               if (decMove)
               begin
                  s_next.fsm = esx_pkg::ST_MOVE;
                  s_next.destSet = 1'b0;
                  s_next.destNop = 1'b0;
                  if (indHit)
                  begin
                     s_next.srcByte = esx_pkg::BYTE_ZERO;
                     s_next.dataHeld = 1'b1;
                     s_next.readPend = 1'b0;
                  end
                  else
                  begin
                     s_next.mem.rdEn = 1'b1;
                     s_next.mem.rdAddr = candAddr;
                     s_next.dataHeld = 1'b0;
                     s_next.readPend = 1'b1;
                  end
               end
               else if (decPush)
               begin
                  s_next.mem.wrEn = 1'b1;
                  s_next.mem.wrAddr = stackPtr;
                  s_next.mem.wrData = instrWord[7:0];
                  s_next.ptr[esx_pkg::STACK_PTR] =
                     stackPtr - esx_pkg::ONE_ADDR;
               end
               else if (decSub)
               begin
                  if (subSel == esx_pkg::SEL_RETURN)
                  begin
                     s_next.ptr[esx_pkg::STACK_PTR] = stackPtr - subLit;
                     s_next.pcLoad = 1'b1;
                     s_next.pcValue = tosValue;
                     s_next.fsm = esx_pkg::ST_RET_NOP;
                  end
                  else
                  begin
                     s_next.ptr[subSel] = s_reg.ptr[subSel] - subLit;
                  end
               end
            end
            esx_pkg::ST_MOVE:
            begin
               if (s_reg.readPend)
               begin
                  s_next.srcByte = memRdData;
                  s_next.readPend = 1'b0;
                  s_next.dataHeld = 1'b1;
               end
               if (!s_reg.destSet && instrValid &&
                  instrWord[15:12] == esx_pkg::OP_WORD2_HI)
               begin
                  s_next.destAddr = candAddr;
                  s_next.destNop = indHit;
                  s_next.destSet = 1'b1;
               end
               if (s_reg.destSet && s_reg.dataHeld)
               begin
                  // Destination rules for program counter and stack bytes
                  // are left to software; no check is made here.
                  s_next.mem.wrEn = !s_reg.destNop;
                  s_next.mem.wrAddr = s_reg.destAddr;
                  s_next.mem.wrData = s_reg.srcByte;
                  s_next.fsm = esx_pkg::ST_IDLE;
               end
            end
            esx_pkg::ST_RET_NOP:
            begin
               s_next.fsm = esx_pkg::ST_IDLE;
            end
            default:
            begin
               s_next.fsm = esx_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         s_reg <= '0;
         s_reg.fsm <= esx_pkg::ST_IDLE;
         s_reg.ptr <= {3{esx_pkg::PTR_RESET}};
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign memReq = s_reg.mem;
   assign pcLoad = s_reg.pcLoad;
   assign pcValue = s_reg.pcValue;
   assign nopSlot = s_reg.fsm == esx_pkg::ST_RET_NOP;
   assign ptrValue = s_reg.ptr;

   // File operand resolution for base byte and bit instructions. Legacy
   // code touching low access addresses lands on stack frame slots once
   // the extension is on, which is why the enable gates it here.
   always_comb
   begin
      resolvedIndexed = extEnable && !baseAccess &&
         baseFile <= esx_pkg::IDX_LIMIT;
      if (resolvedIndexed)
      begin
         resolvedAddr = stackPtr + {4'h0, baseFile};
      end
      else if (baseAccess)
      begin
         resolvedAddr = {bankSel, baseFile};
      end
      else if (baseFile <= esx_pkg::IDX_LIMIT)
      begin
         resolvedAddr = {esx_pkg::ACC_LOW_BANK, baseFile};
      end
      else
      begin
         resolvedAddr = {esx_pkg::ACC_HIGH_BANK, baseFile};
      end
   end

   assign destToAcc = !baseDest;

   a_push_write: assert property (@(posedge mclk) disable iff (rst)
      decPush |=> memReq.wrEn && memReq.wrAddr == $past(stackPtr) &&
         memReq.wrData == $past(instrWord[7:0]))
      else $error("push did not store literal at stack pointer");

   a_push_dec: assert property (@(posedge mclk) disable iff (rst)
      decPush |=> ptrValue[2] == $past(stackPtr) - 12'h001)
      else $error("push did not decrement stack pointer");

   a_sub_ptr: assert property (@(posedge mclk) disable iff (rst)
      decSub && subSel == 2'h1 |=>
         ptrValue[1] == $past(s_reg.ptr[1]) - $past(subLit))
      else $error("pointer subtract result wrong");

   a_ret_two: assert property (@(posedge mclk) disable iff (rst)
      decSub && subSel == 2'h3 |=> pcLoad && nopSlot &&
         pcValue == $past(tosValue) ##1 !nopSlot && !pcLoad)
      else $error("return did not take exactly two cycles");

   a_ret_idle: assert property (@(posedge mclk) disable iff (rst)
      nopSlot |-> !instrAccept && !extDecoded && !memReq.wrEn)
      else $error("idle return slot accepted work");

   a_src_zero: assert property (@(posedge mclk) disable iff (rst)
      decMove && indHit |=> !memReq.rdEn && s_reg.srcByte == 8'h00)
      else $error("indirect source was not read as zero");

   a_src_read: assert property (@(posedge mclk) disable iff (rst)
      decMove && !indHit |=> memReq.rdEn &&
         memReq.rdAddr == $past(candAddr))
      else $error("move source read address wrong");

   a_dst_nop: assert property (@(posedge mclk) disable iff (rst)
      ce && s_reg.fsm == esx_pkg::ST_MOVE && s_reg.destSet &&
         s_reg.dataHeld && s_reg.destNop |=> !memReq.wrEn)
      else $error("write to indirect destination not suppressed");

   a_ext_gate: assert property (@(posedge mclk) disable iff (rst)
      !extEnable |-> !extDecoded && !resolvedIndexed)
      else $error("extension active while disabled");

   a_legacy_map: assert property (@(posedge mclk) disable iff (rst)
      resolvedIndexed && stackPtr == 12'h000 |->
         resolvedAddr == {4'h0, baseFile})
      else $error("zero pointer did not restore legacy mapping");

   a_ce_freeze: assert property (@(posedge mclk) disable iff (rst)
      !ce |=> ptrValue == $past(ptrValue) && memReq == $past(memReq))
      else $error("state moved while clock enable was low");

endmodule

/* tb_top.sv */
// Self-checking bench for the extended stack instruction executor.
// Assumes esx_pkg is compiled first; the bench plays core and data memory.
`timescale 1ns/100ps

module tb_top;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic extEnable = 1'b1;
   logic instrValid = 1'b0;
   logic [15:0] instrWord = 16'h0000;
   logic [20:0] tosValue = 21'h0_0000;
   logic [7:0] memRdData = 8'h00;
   logic ptrLoad = 1'b0;
   logic [1:0] ptrLoadSel = 2'h0;
   logic [11:0] ptrLoadData = 12'h000;
   logic [7:0] baseFile = 8'h00;
   logic baseAccess = 1'b0;
   logic baseDest = 1'b0;
   logic [3:0] bankSel = 4'h0;
   logic instrAccept, extDecoded, pcLoad, nopSlot, resolvedIndexed, destToAcc;
   logic [20:0] pcValue;
   logic [11:0] resolvedAddr;
   logic [2:0][11:0] ptrValue;
   esx_pkg::esx_mem_req_t memReq;
   int numErrors = 0;
   int nTests = 0;
   int cycles = 0;
   logic [31:0] rnd = 32'h0000_5e49;
   logic [11:0] expPtr [3];
   logic [19:0] wrQ [$];
   logic [11:0] rdQ [$];
   logic [20:0] pcQ [$];

   esx_exec dut (.mclk(mclk), .rst(rst), .ce(ce), .extEnable(extEnable),
      .instrValid(instrValid), .instrWord(instrWord),
      .instrAccept(instrAccept), .extDecoded(extDecoded),
      .tosValue(tosValue), .pcLoad(pcLoad), .pcValue(pcValue),
      .nopSlot(nopSlot), .memReq(memReq), .memRdData(memRdData),
      .ptrLoad(ptrLoad), .ptrLoadSel(ptrLoadSel), .ptrLoadData(ptrLoadData),
      .ptrValue(ptrValue), .baseFile(baseFile), .baseAccess(baseAccess),
      .baseDest(baseDest), .bankSel(bankSel), .resolvedAddr(resolvedAddr),
      .resolvedIndexed(resolvedIndexed), .destToAcc(destToAcc));

   always #5 mclk = ~mclk;

   task automatic stopTest;
      if (numErrors == 0 && nTests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] exp,
      input logic [31:0] got);
      nTests++;
      if (got !== exp)
      begin
         numErrors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic step;
      rnd = rnd ^ (rnd << 13);
      rnd = rnd ^ (rnd >> 17);
      rnd = rnd ^ (rnd << 5);
   endtask

   // The word is held until the design accepts it, then withdrawn.
   task automatic issue(input logic [15:0] w, input logic expExt);
      int n;
      n = 0;
      @(negedge mclk);
      instrValid = 1'b1;
      instrWord = w;
      #1;
      while (instrAccept !== 1'b1 && n < 10)
      begin
         @(negedge mclk);
         #1;
         n++;
      end
      check("instrAccept", 1, instrAccept);
      check("extDecoded", expExt, extDecoded);
      @(negedge mclk);
      instrValid = 1'b0;
   endtask

   task automatic setPtr(input logic [1:0] sel, input logic [11:0] v);
      @(negedge mclk);
      ptrLoad = 1'b1;
      ptrLoadSel = sel;
      ptrLoadData = v;
      expPtr[sel] = v;
      @(negedge mclk);
      ptrLoad = 1'b0;
   endtask

   // Memory answers with an address-derived byte so each move is traceable.
   always @(negedge mclk)
   begin
      step();
      memRdData <= memReq.rdEn ? (memReq.rdAddr[7:0] ^ 8'hA5) : rnd[15:8];
      if (!rst && memReq.wrEn === 1'b1)
         check("write", wrQ.size() ? wrQ.pop_front() : 20'hx,
            {memReq.wrAddr, memReq.wrData});
      if (!rst && memReq.rdEn === 1'b1)
         check("rdAddr", rdQ.size() ? rdQ.pop_front() : 12'hx,
            memReq.rdAddr);
      if (!rst && pcLoad === 1'b1)
      begin
         check("pcValue", pcQ.size() ? pcQ.pop_front() : 21'hx,
            pcValue);
         check("nopSlot", 1, nopSlot);
         check("retAccept", 0, instrAccept);
      end
   end

   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         numErrors++;
         stopTest();
      end
   end

   task automatic move(input logic [15:0] w1, input logic [15:0] w2);
      issue(w1, 1'b1);
      issue(w2, 1'b0);
      repeat (4) @(negedge mclk);
   endtask

   initial
   begin
      logic [5:0] k;
      logic [11:0] exp;
      repeat (10) @(negedge mclk);
      rst = 1'b0;
      check("ptrReset", 0, {8'h00, ptrValue[1:0]});
      check("ptrReset", 0, ptrValue[2]);
      setPtr(2'h2, 12'h1EC);
      wrQ.push_back({12'h1EC, 8'h08});
      issue(16'hFA08, 1'b1);
      check("ptrPush", 12'h1EB, ptrValue[2]);
      for (int s = 0; s < 3; s++)
      begin
         step();
         setPtr(s[1:0], rnd[11:0]);
         k = rnd[21:16];
         issue({8'hE9, s[1:0], k}, 1'b1);
         expPtr[s] = expPtr[s] - {6'h00, k};
         check("ptrSub", expPtr[s], ptrValue[s]);
      end
      // A word offered with the enable low must leave everything alone.
      @(negedge mclk);
      ce = 1'b0;
      instrValid = 1'b1;
      instrWord = 16'hFA33;
      #1;
      check("ceAccept", 0, instrAccept);
      @(negedge mclk);
      check("cePtr", expPtr[2], ptrValue[2]);
      instrValid = 1'b0;
      ce = 1'b1;
      step();
      tosValue = rnd[20:0];
      pcQ.push_back(rnd[20:0]);
      issue({8'hE9, 2'h3, 6'h3F}, 1'b1);
      check("ptrRet", expPtr[2] - 12'h03F, ptrValue[2]);
      setPtr(2'h2, 12'h080);
      rdQ.push_back(12'h085);
      wrQ.push_back({12'h086, 8'h85 ^ 8'hA5});
      move(16'hEB85, 16'hF006);
      setPtr(2'h2, 12'hFF0);
      wrQ.push_back({12'h000, 8'h00});
      move(16'hEB80, 16'hF010);
      setPtr(2'h2, 12'hF80);
      rdQ.push_back(12'hF85);
      move(16'hEB85, 16'hF060);
      extEnable = 1'b0;
      issue(16'hFA55, 1'b0);
      issue(16'hE9C1, 1'b0);
      check("ptrOff", 12'hF80, ptrValue[2]);
      for (int i = 0; i < 40; i++)
      begin
         step();
         if (i == 10)
            setPtr(2'h2, 12'h000);
         if (i == 20)
            setPtr(2'h2, rnd[27:16]);
         @(negedge mclk);
         extEnable = rnd[0];
         baseAccess = rnd[1];
         baseDest = rnd[2];
         bankSel = rnd[7:4];
         baseFile = rnd[15:8];
         #1;
         if (extEnable && !baseAccess && baseFile <= 8'h5F)
            exp = expPtr[2] + {4'h0, baseFile};
         else if (!baseAccess)
            exp = {(baseFile <= 8'h5F) ? 4'h0 : 4'hF, baseFile};
         else
            exp = {bankSel, baseFile};
         check("resolvedAddr", exp, resolvedAddr);
         check("resolvedIndexed", extEnable && !baseAccess &&
            baseFile <= 8'h5F, resolvedIndexed);
         check("destToAcc", !baseDest, destToAcc);
      end
      repeat (4) @(negedge mclk);
      check("queues", 0, wrQ.size() + rdQ.size() + pcQ.size());
      stopTest();
   end
endmodule
